// file: core/tws_slave.sv
`timescale 1ns/1ps
`default_nettype none
module tws_slave
    import tws_pkg::*;
#(
    parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
    input  wire logic              clock_in,
    input  wire logic              resetn_in,
    input  wire logic              scl_in,
    input  wire logic              sda_in,
    output logic                   sda_out,
    output logic                   sda_oe_out,
    input  wire logic              id_load_in,
    input  wire logic [ID_W-1:0]   id_value_in,
    output logic [ID_W-1:0]        target_bus_id_out,
    output logic [PTR_W-1:0]       rd_addr_out,
    input  wire logic [DATA_W-1:0] rd_data_in,
    output logic                   wr_valid_out,
    input  wire logic              wr_ready_in,
    output tws_wr_s                wr_data_out,
    output logic                   busy_out
);
    logic [1:0]        rst_sync_r;
    logic              rst_n;
    logic [1:0]        line_s1_r;
    logic [1:0]        line_s2_r;
    logic [1:0]        line_s3_r;
    logic [1:0]        line_f_r;
    logic [1:0]        line_fn;
    logic              scl_f;
    logic              scl_p;
    logic              sda_f;
    logic              sda_p;
    logic              rise;
    logic              fall;
    logic              start_det;
    logic              stop_det;
    tws_state_e        state_r;
    tws_state_e        sack_next_r;
    logic [3:0]        bit_cnt_r;
    logic [7:0]        shift_r;
    logic [7:0]        tx_r;
    logic [PTR_W-1:0]  memory_pointer_r;
    logic              ptr_over_r;
    logic [PTR_W-1:0]  wr_addr_r;
    logic              wr_skip_r;
    logic [ID_W-1:0]   target_bus_id_r;
    logic              sda_oe_r;
    logic              rx_state;
    logic              rx_rise;
    logic              data_rise;
    logic              lsb_rise;
    logic              byte_done;
    logic              ack_now;
    logic              load_fall;
    logic              tx_fall;
    logic              tx_end;
    logic [7:0]        load_byte;
    logic              push;
    logic              fifo_ready;
    tws_wr_s           push_word;

    // reset release through two flops
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // bit 1 is the clock line, bit 0 the data line
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            line_s1_r <= LINE_IDLE;
            line_s2_r <= LINE_IDLE;
            line_s3_r <= LINE_IDLE;
            line_f_r  <= LINE_IDLE;
        end else begin
            line_s1_r <= {scl_in, sda_in};
            line_s2_r <= line_s1_r;
            line_s3_r <= line_s2_r;
            line_f_r  <= line_fn;
        end
    end

    // a level must hold two samples to pass; spikes are dropped
    // used before its register to save a cycle of data-line turnaround
    assign line_fn = (line_s2_r & line_s3_r)
                   | (line_f_r & (line_s2_r | line_s3_r));

    assign scl_f = line_fn[1];
    assign sda_f = line_fn[0];
    assign scl_p = line_f_r[1];
    assign sda_p = line_f_r[0];

    // latency of a few cycles is far below the shortest clock phase
    // at 400kHz, so no rate setting is needed
    assign rise      = scl_f && !scl_p;
    assign fall      = !scl_f && scl_p;
    assign start_det = scl_f && scl_p && sda_p && !sda_f;
    assign stop_det  = scl_f && scl_p && !sda_p && sda_f;

    assign rx_state  = (state_r == ST_ADDR) || (state_r == ST_PTR)
                    || (state_r == ST_WDATA);
    assign rx_rise   = rise && rx_state;
    assign data_rise = rise && (rx_state || state_r == ST_RDATA);
    assign lsb_rise  = data_rise && (bit_cnt_r == LSB_BIT);
    assign byte_done = fall && rx_state && (bit_cnt_r == BYTE_BITS);
    assign tx_fall   = fall && (state_r == ST_RDATA)
                    && (bit_cnt_r != BYTE_BITS);
    assign tx_end    = fall && (state_r == ST_RDATA)
                    && (bit_cnt_r == BYTE_BITS);
    assign load_fall = fall && ((state_r == ST_SACK && sack_next_r == ST_RDATA)
                    || state_r == ST_MACK);
    assign load_byte = ptr_over_r ? RD_PAST_TOP : rd_data_in;

    // full buffer: the byte is refused with a nak and not stored
    always_comb begin
        unique case (state_r)
            ST_ADDR:  ack_now = (shift_r[7:1] == target_bus_id_r);
            ST_PTR:   ack_now = 1'b1;
            ST_WDATA: ack_now = fifo_ready;
            default:  ack_now = 1'b0;
        endcase
    end

    assign push = byte_done && (state_r == ST_WDATA)
               && ack_now && !wr_skip_r;
    assign push_word.addr = wr_addr_r;
    assign push_word.data = shift_r;

    // target id, reloadable from the owner of the id store
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            target_bus_id_r <= ID_RESET;
        end else if (id_load_in) begin
            target_bus_id_r <= id_value_in;
        end
    end

    // sequencer
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            state_r     <= ST_IDLE;
            sack_next_r <= ST_IDLE;
            bit_cnt_r   <= 4'h0;
        end else if (stop_det) begin
            state_r <= ST_IDLE;
        end else if (start_det) begin
            state_r   <= ST_ADDR;
            bit_cnt_r <= 4'h0;
        end else if (data_rise) begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
        end else if (rise && state_r == ST_MACK && sda_f) begin
            state_r <= ST_IDLE;
        end else if (byte_done) begin
            state_r <= ack_now ? ST_SACK : ST_IDLE;
            unique case (state_r)
                ST_ADDR: begin
                    sack_next_r <= shift_r[0] ? ST_RDATA : ST_PTR;
                end
                default: begin
                    sack_next_r <= ST_WDATA;
                end
            endcase
        end else if (fall && state_r == ST_SACK) begin
            state_r   <= sack_next_r;
            bit_cnt_r <= 4'h0;
        end else if (fall && state_r == ST_MACK) begin
            state_r   <= ST_RDATA;
            bit_cnt_r <= 4'h0;
        end else if (tx_end) begin
            state_r <= ST_MACK;
        end
    end

    // receive shifter, msb first
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            shift_r <= 8'h00;
        end else if (rx_rise) begin
            shift_r <= {shift_r[6:0], sda_f};
        end
    end

    // pointer survives a repeated start so a read follows its setup
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            memory_pointer_r <= PTR_RESET;
            ptr_over_r       <= 1'b0;
            wr_addr_r        <= PTR_RESET;
            wr_skip_r        <= 1'b0;
        end else if (lsb_rise && state_r == ST_PTR) begin
            memory_pointer_r <= {shift_r[6:0], sda_f};
            ptr_over_r       <= 1'b0;
        end else if (lsb_rise && state_r != ST_ADDR) begin
            if (state_r == ST_WDATA) begin
                wr_addr_r <= memory_pointer_r;
                wr_skip_r <= ptr_over_r;
            end
            // ascending steps keep the high byte at the even address
            memory_pointer_r <= memory_pointer_r + 1'b1;
            if (memory_pointer_r == PTR_TOP) begin
                ptr_over_r <= 1'b1;
            end
        end
    end

    // transmit shifter
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            tx_r <= 8'h00;
        end else if (load_fall) begin
            tx_r <= load_byte;
        end else if (tx_fall) begin
            tx_r <= {tx_r[6:0], 1'b1};
        end
    end

    // open-drain drive; every change except the release at a start or stop lands just after a clock fall
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            sda_oe_r <= 1'b0;
        end else if (start_det || stop_det) begin
            sda_oe_r <= 1'b0;
        end else if (byte_done) begin
            sda_oe_r <= ack_now;
        end else if (load_fall) begin
            sda_oe_r <= !load_byte[7];
        end else if (fall && state_r == ST_SACK) begin
            sda_oe_r <= 1'b0;
        end else if (tx_fall) begin
            sda_oe_r <= !tx_r[6];
        end else if (tx_end) begin
            sda_oe_r <= 1'b0;
        end
    end

    // read address tracks the pointer with a register stage
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            rd_addr_out <= PTR_RESET;
            busy_out    <= 1'b0;
        end else begin
            rd_addr_out <= memory_pointer_r;
            busy_out    <= (state_r != ST_IDLE);
        end
    end

    assign sda_out           = 1'b0;
    assign sda_oe_out        = sda_oe_r;
    assign target_bus_id_out = target_bus_id_r;

    tws_fifo #(
        .WIDTH (PTR_W + DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock_in      (clock_in),
        .rst_n_in      (rst_n),
        .in_valid_in   (push),
        .in_ready_out  (fifo_ready),
        .in_data_in    (push_word),
        .out_valid_out (wr_valid_out),
        .out_ready_in  (wr_ready_in),
        .out_data_out  (wr_data_out)
    );

    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_n);

    AST_START_OPENS: assert property (
        start_det && !stop_det |=> state_r == ST_ADDR && bit_cnt_r == 4'h0)
        else $error("start did not open address phase");

    AST_STOP_ENDS: assert property (
        stop_det |=> state_r == ST_IDLE && !sda_oe_r)
        else $error("stop did not end transaction");

    AST_RESTART_KEEPS_PTR: assert property (
        start_det && state_r != ST_IDLE |=> $stable(memory_pointer_r))
        else $error("repeated start disturbed the pointer");

    AST_DRIVE_CLOCK_LOW: assert property (
        $changed(sda_oe_r) && !$past(start_det || stop_det)
        |-> !$past(scl_f))
        else $error("data drive changed while clock high");

    AST_ACK_HELD: assert property (
        state_r == ST_SACK && scl_f |-> sda_oe_r)
        else $error("ack released while clock high");

    AST_ID_MISMATCH_NAK: assert property (
        byte_done && state_r == ST_ADDR
        && shift_r[7:1] != target_bus_id_r
        |=> !sda_oe_r ##1 state_r == ST_IDLE)
        else $error("foreign address was acknowledged");

    AST_ID_MATCH_ACK: assert property (
        byte_done && state_r == ST_ADDR
        && shift_r[7:1] == target_bus_id_r
        |=> sda_oe_r && state_r == ST_SACK)
        else $error("own address not acknowledged");

    AST_PTR_LOAD: assert property (
        lsb_rise && state_r == ST_PTR
        |=> memory_pointer_r == {7'($past(shift_r)), $past(sda_f)})
        else $error("pointer byte not loaded");

    AST_PTR_STEP: assert property (
        lsb_rise && (state_r == ST_WDATA || state_r == ST_RDATA)
        |=> memory_pointer_r == $past(memory_pointer_r) + 8'h01)
        else $error("pointer did not step after lsb");

    AST_PAST_TOP_ONES: assert property (
        load_fall && ptr_over_r |=> tx_r == RD_PAST_TOP)
        else $error("read past top not all ones");

    AST_NO_PARTIAL_STORE: assert property (
        push |-> state_r == ST_WDATA && bit_cnt_r == BYTE_BITS && fall)
        else $error("store outside a completed byte");

    AST_NAK_RELEASE: assert property (
        rise && state_r == ST_MACK && sda_f && !stop_det && !start_det
        |=> state_r == ST_IDLE [*2] ##0 !sda_oe_r)
        else $error("slave kept line after master nak");
endmodule
`default_nettype wire

// file: core/tws_pkg.sv
package tws_pkg;
    localparam int          ID_W           = 7;
    localparam int          PTR_W          = 8;
    localparam int          DATA_W         = 8;
    localparam logic [6:0]  ID_RESET       = 7'h34;
    localparam logic [7:0]  PTR_RESET      = 8'h00;
    localparam logic [7:0]  PTR_TOP        = 8'hFF;
    localparam logic [7:0]  RD_PAST_TOP    = 8'hFF;
    localparam logic [3:0]  BYTE_BITS      = 4'h8;
    localparam logic [3:0]  LSB_BIT        = 4'h7;
    localparam logic [1:0]  LINE_IDLE      = 2'h3;
    localparam int          FIFO_DEPTH_DEF = 16;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ADDR  = 3'b001,
        ST_PTR   = 3'b010,
        ST_WDATA = 3'b011,
        ST_SACK  = 3'b100,
        ST_RDATA = 3'b101,
        ST_MACK  = 3'b110
    } tws_state_e;

    typedef struct packed {
        logic [PTR_W-1:0]  addr;
        logic [DATA_W-1:0] data;
    } tws_wr_s;
endpackage

// file: core/tws_fifo.sv
`timescale 1ns/1ps
`default_nettype none
// depth must be a power of two so the pointers wrap on their own
module tws_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic             clock_in,
    input  wire logic             rst_n_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wp_r;
    logic [AW-1:0]    rp_r;
    logic [AW:0]      cnt_r;
    logic             push;
    logic             pop;

    assign in_ready_out  = (cnt_r != DEPTH[AW:0]);
    assign out_valid_out = (cnt_r != '0);
    assign out_data_out  = mem_r[rp_r];
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;

    always_ff @(posedge clock_in) begin
        if (push) begin
            mem_r[wp_r] <= in_data_in;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= rp_r + 1'b1;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// file: bench/tws_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// bus master: clock driven push-pull, data only pulled low or released
module tws_master_model (
    output logic      scl_out,
    output logic      sda_oe_out,
    input  wire logic sda_in
);
    // 320 ns bit: low 200 ns, high 120 ns; data moves 80 ns into low
    // the long low phase leaves room for the slave's sampling latency
    localparam realtime QTR    = 80.0;
    localparam realtime T_RISE = 120.0;
    localparam realtime T_HIGH = 60.0;

    initial begin
        scl_out    = 1'b1;
        sda_oe_out = 1'b0;
    end

    // one clock pulse; data moves only in the low phase
    task automatic bit_cycle(input logic pull_low, output logic seen);
        #(QTR) sda_oe_out = pull_low;
        #(T_RISE) scl_out = 1'b1;
        #(T_HIGH) seen = sda_in;
        #(T_HIGH) scl_out = 1'b0;
    endtask

    // from idle, or mid-transfer as a repeated start
    task automatic start();
        #13;
        if (!scl_out) begin
            #(QTR) sda_oe_out = 1'b0;
            #(QTR) scl_out = 1'b1;
        end
        #(QTR) sda_oe_out = 1'b1;
        #(QTR) scl_out = 1'b0;
    endtask

    // leaves the bus idle: both lines high
    task automatic stop();
        #(QTR) sda_oe_out = 1'b1;
        #(QTR) scl_out = 1'b1;
        #(QTR) sda_oe_out = 1'b0;
        #(QTR);
    endtask

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(!b[i], s);
        end
        bit_cycle(1'b0, s);
        ack = !s;
    endtask

    task automatic recv_byte(input logic ack_me, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b0, s);
            b[i] = s;
        end
        bit_cycle(ack_me, s);
    endtask
endmodule
`default_nettype wire

// file: bench/test_tws_slave.sv
`timescale 1ns/1ps
`default_nettype none
module test_tws_slave;
    import tws_pkg::*;
    logic              clock_in  = 1'b0;
    logic              resetn_in = 1'b0;
    logic              scl;
    logic              m_oe;
    logic              s_oe;
    logic              sda_low;
    logic              sda;
    logic              id_load;
    logic [ID_W-1:0]   id_value;
    logic [ID_W-1:0]   tgt_id;
    logic [PTR_W-1:0]  rd_addr;
    logic [DATA_W-1:0] rd_data;
    logic              wr_valid;
    logic              wr_ready;
    tws_wr_s           wr_data;
    logic              busy;
    int                err_total = 0;
    int                cmp_count = 0;
    int                cyc = 0;

    always #20 clock_in = ~clock_in;
    // pull-up wins unless someone pulls low
    assign sda = !(m_oe || (s_oe && !sda_low));
    // memory stand-in: byte value derived from its address
    assign rd_data = rd_addr ^ 8'h5A;

    tws_master_model tws_master_model_inst (
        .scl_out    (scl),
        .sda_oe_out (m_oe),
        .sda_in     (sda)
    );

    tws_slave #(.FIFO_DEPTH(16)) tws_slave_inst (
        .clock_in          (clock_in),
        .resetn_in         (resetn_in),
        .scl_in            (scl),
        .sda_in            (sda),
        .sda_out           (sda_low),
        .sda_oe_out        (s_oe),
        .id_load_in        (id_load),
        .id_value_in       (id_value),
        .target_bus_id_out (tgt_id),
        .rd_addr_out       (rd_addr),
        .rd_data_in        (rd_data),
        .wr_valid_out      (wr_valid),
        .wr_ready_in       (wr_ready),
        .wr_data_out       (wr_data),
        .busy_out          (busy)
    );

    task automatic results();
        if (err_total == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic send(input logic [7:0] b, input logic exp);
        logic ack;
        tws_master_model_inst.send_byte(b, ack);
        check(16'(ack), 16'(exp));
    endtask

    task automatic address(input logic [6:0] id, input logic rw,
                           input logic exp);
        tws_master_model_inst.start();
        send({id, rw}, exp);
    endtask

    task automatic settle_stop();
        tws_master_model_inst.stop();
        repeat (6) @(negedge clock_in);
        check(16'({busy, s_oe}), 16'h0000);
    endtask

    // consumer side: takes n words, then expects the buffer empty
    task automatic drain(input logic [7:0] a0, input logic [7:0] d0,
                         input int n);
        @(negedge clock_in);
        for (int i = 0; i < n; i++) begin
            for (int w = 0; w < 20 && wr_valid !== 1'b1; w++) begin
                @(negedge clock_in);
            end
            check(wr_data, {a0 + 8'(i), d0 + 8'(i)});
            wr_ready = 1'b1;
            @(negedge clock_in);
            wr_ready = 1'b0;
        end
        repeat (2) @(negedge clock_in);
        check(16'(wr_valid), 16'h0000);
    endtask

    task automatic t_reset();
        check(16'(tgt_id), 16'(ID_RESET));
        check(16'({busy, s_oe, wr_valid}), 16'h0000);
    endtask

    // a read probe must take one byte and nak it, or the slave holds data
    task automatic t_probe();
        logic [7:0] b;
        address(ID_RESET, 1'b0, 1'b1);
        check(16'(busy), 16'h0001);
        settle_stop();
        address(ID_RESET ^ 7'h01, 1'b0, 1'b0);
        settle_stop();
        address(ID_RESET, 1'b1, 1'b1);
        tws_master_model_inst.recv_byte(1'b0, b);
        check(16'(b), 16'(PTR_RESET ^ 8'h5A));
        settle_stop();
    endtask

    // consumer stalls: sixteen words fit, the seventeenth is refused
    task automatic t_write_full();
        address(ID_RESET, 1'b0, 1'b1);
        send(8'h20, 1'b1);
        for (int i = 0; i < 17; i++) begin
            send(8'h80 + 8'(i), 1'(i < 16));
        end
        settle_stop();
        drain(8'h20, 8'h80, 16);
        // the refused byte is sent again once the buffer has room
        address(ID_RESET, 1'b0, 1'b1);
        send(8'h30, 1'b1);
        send(8'h90, 1'b1);
        settle_stop();
        drain(8'h30, 8'h90, 1);
    endtask

    // second byte lands past the top and must be dropped
    task automatic t_top_write();
        address(ID_RESET, 1'b0, 1'b1);
        send(8'hFF, 1'b1);
        send(8'h11, 1'b1);
        send(8'h12, 1'b1);
        settle_stop();
        drain(8'hFF, 8'h11, 1);
    endtask

    task automatic t_read();
        logic [7:0] b;
        address(ID_RESET, 1'b0, 1'b1);
        send(8'hFE, 1'b1);
        address(ID_RESET, 1'b1, 1'b1);
        tws_master_model_inst.recv_byte(1'b1, b);
        check(16'(b), 16'(8'hFE ^ 8'h5A));
        tws_master_model_inst.recv_byte(1'b1, b);
        check(16'(b), 16'(8'hFF ^ 8'h5A));
        tws_master_model_inst.recv_byte(1'b0, b);
        check(16'(b), 16'(RD_PAST_TOP));
        repeat (8) @(negedge clock_in);
        check(16'(s_oe), 16'h0000);
        settle_stop();
    endtask

    task automatic t_reload();
        @(negedge clock_in);
        id_value = 7'h51;
        id_load  = 1'b1;
        @(negedge clock_in);
        id_load  = 1'b0;
        @(negedge clock_in);
        check(16'(tgt_id), 16'h0051);
        address(7'h51, 1'b0, 1'b1);
        settle_stop();
        address(ID_RESET, 1'b0, 1'b0);
        settle_stop();
    endtask

    // hang guard: the whole sequence needs about 3000 cycles
    always @(posedge clock_in) begin
        cyc = cyc + 1;
        if (cyc == 10000) begin
            err_total = err_total + 1;
            results();
        end
    end

    initial begin
        wr_ready = 1'b0;
        id_load  = 1'b0;
        id_value = 7'h00;
        repeat (10) @(negedge clock_in);
        resetn_in = 1'b1;
        repeat (12) @(negedge clock_in);
        t_reset();
        t_probe();
        t_write_full();
        t_top_write();
        t_read();
        t_reload();
        results();
    end
endmodule
`default_nettype wire
